// file: verilog/cell_nibble_rx_pkg.sv
// package: constants for the fast channel one receive pin block
package cell_nibble_rx_pkg;
    // ----------------------------------------
    // widths and cell framing
    // ----------------------------------------
    localparam int OCTET_W = 8;
    localparam int NIBBLE_W = 4;
    localparam int CELL_OCTETS = 53;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_LAST = 6'h34;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
    localparam logic [OCTET_W-1:0] OCTET_RESET = 8'h00;
    localparam logic [NIBBLE_W-1:0] NIBBLE_RESET = 4'h0;
    localparam int MODULE_CODE_W = 5;
    localparam logic [MODULE_CODE_W-1:0] MODULE_CODE_RESET = 5'h00;
    // direction bit: transmit low, receive high
    localparam logic DIR_TX = 1'b0;
    localparam logic DIR_RX = 1'b1;
    // ----------------------------------------
    // protocol modes
    // ----------------------------------------
    typedef enum logic [1:0] {MODE_CELL, MODE_NIBBLE, MODE_OFF} rx_mode_type;
endpackage : cell_nibble_rx_pkg

// file: verilog/cell_nibble_receive_pins.sv
// module: receive data pins and serial dma monitor of fast channel one
`timescale 1ns/1ns
// How it works
// [R1] cell octets on eight lines, bit7 msb
// [R2] cells are 53 octets, counted to delimit
// [R3] source sends idle cells when empty
// [R4] source drives bus only while enable asserted
// [R5] nibble modes use lines 3..0, 3 msb
// [R6] five-bit module code on monitor outputs
// [R7] sixth monitor bit: transmit low, receive high
// [R8] sample synchronously, ignore bus when disabled
module cell_nibble_receive_pins
    import cell_nibble_rx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // mode select
    input wire logic [1:0] rx_mode,
    // receive pins from the physical layer
    input wire logic [OCTET_W-1:0] rx_data_pins,
    input wire logic rx_bus_enable_strobe,
    // received data out
    output logic [OCTET_W-1:0] rx_octet,
    output logic rx_octet_valid,
    output logic rx_cell_start,
    output logic rx_cell_end,
    output logic [NIBBLE_W-1:0] rx_nibble,
    output logic rx_nibble_valid,
    // serial dma monitor
    input wire logic [MODULE_CODE_W-1:0] serial_dma_unit_code,
    input wire logic serial_dma_unit_is_rx,
    output logic [MODULE_CODE_W-1:0] dma_module_code,
    output logic dma_module_dir
);
    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    // capture and count clearing must agree on the decode, so it lives in one place
    function automatic logic mode_is(input logic [1:0] mode, input rx_mode_type want);
        return (mode == want);
    endfunction : mode_is

    // ----------------------------------------
    // sampling
    // ----------------------------------------
    logic [CNT_W-1:0] octet_cnt_reg;
    logic [CNT_W-1:0] octet_cnt_next;
    logic in_cell_mode;
    logic cell_take;
    logic nib_take;
    logic at_first;
    logic at_last;

    assign in_cell_mode = mode_is(rx_mode, MODE_CELL);
    // other sources may own the floating bus, so only strobed octets are taken
    assign cell_take = in_cell_mode && rx_bus_enable_strobe; // [R8] [R4]
    assign nib_take = mode_is(rx_mode, MODE_NIBBLE); // [R8]
    assign at_first = (octet_cnt_reg == CNT_RESET);
    assign at_last = (octet_cnt_reg == CNT_LAST); // [R2]
    // wraps after the last octet; idle cells are counted like any other [R3]
    assign octet_cnt_next = at_last ? CNT_RESET : octet_cnt_reg + 6'h01; // [R2]

    // ----------------------------------------
    // cell octet counter
    // ----------------------------------------
    // no resync on header content: a slip is only recovered by a mode change or a reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            octet_cnt_reg <= CNT_RESET;
        end
        else if (clk_en)
        begin
            // leaving cell mode abandons a partial cell
            if (!in_cell_mode)
            begin
                octet_cnt_reg <= CNT_RESET;
            end
            else if (cell_take)
            begin
                octet_cnt_reg <= octet_cnt_next; // [R2]
            end
        end
    end

    // ----------------------------------------
    // captured octet and cell markers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_octet <= OCTET_RESET;
        end
        else if (clk_en && cell_take)
        begin
            rx_octet <= rx_data_pins; // [R1]
        end
    end

    // markers ride in the same cycle as the octet they belong to
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_octet_valid <= 1'b0;
            rx_cell_start <= 1'b0;
            rx_cell_end <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_octet_valid <= cell_take; // [R8]
            rx_cell_start <= cell_take && at_first; // [R2]
            rx_cell_end <= cell_take && at_last; // [R2]
        end
    end

    // ----------------------------------------
    // nibble capture
    // ----------------------------------------
    // nibble modes have no enable strobe: every enabled edge is a sample
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_nibble <= NIBBLE_RESET;
            rx_nibble_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_nibble_valid <= nib_take;
            if (nib_take)
            begin
                rx_nibble <= rx_data_pins[NIBBLE_W-1:0]; // [R5]
            end
        end
    end

    // ----------------------------------------
    // serial dma monitor
    // ----------------------------------------
    // shadows the unit one cycle late; a code shorter than a cycle is lost
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dma_module_code <= MODULE_CODE_RESET;
            dma_module_dir <= DIR_TX;
        end
        else if (clk_en)
        begin
            dma_module_code <= serial_dma_unit_code; // [R6]
            dma_module_dir <= serial_dma_unit_is_rx ? DIR_RX : DIR_TX; // [R7]
        end
    end

    // ----------------------------------------
    // checks: cell bus
    // ----------------------------------------
    a_octet_capture: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        (clk_en && cell_take) |=> (rx_octet == $past(rx_data_pins) && rx_octet_valid))
        else $error("octet not captured");
    a_disabled_ignored: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
        (clk_en && !rx_bus_enable_strobe) |=> !rx_octet_valid)
        else $error("bus sampled while disabled");
    a_enable_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        (clk_en && !cell_take) |=> $stable(rx_octet))
        else $error("octet changed without enable");
    a_cell_count: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        octet_cnt_reg <= CNT_LAST)
        else $error("octet count beyond cell");
    a_cell_wrap: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        (clk_en && cell_take && octet_cnt_reg == CNT_LAST) |=> (rx_cell_end && octet_cnt_reg == CNT_RESET))
        else $error("cell did not end at 53 octets");
    a_cell_start: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        (clk_en && cell_take && octet_cnt_reg == CNT_RESET) |=> (rx_cell_start && !rx_cell_end))
        else $error("cell start not marked");
    a_start_only: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        (clk_en && !(cell_take && octet_cnt_reg == CNT_RESET)) |=> !rx_cell_start)
        else $error("cell start marked off the first octet");
    a_end_only: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        (clk_en && !(cell_take && octet_cnt_reg == CNT_LAST)) |=> !rx_cell_end)
        else $error("cell end marked off the last octet");
    a_count_clear: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        (clk_en && !in_cell_mode) |=> (octet_cnt_reg == CNT_RESET && !rx_octet_valid))
        else $error("count kept outside cell mode");
    a_count_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
        (clk_en && in_cell_mode && !rx_bus_enable_strobe) |=> $stable(octet_cnt_reg))
        else $error("count moved without enable");

    // ----------------------------------------
    // checks: nibble lines
    // ----------------------------------------
    a_nibble_lines: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
        (clk_en && nib_take) |=> (rx_nibble == $past(rx_data_pins[3:0]) && !rx_octet_valid))
        else $error("nibble wrong");
    a_nibble_idle: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
        (clk_en && !nib_take) |=> (!rx_nibble_valid && $stable(rx_nibble)))
        else $error("nibble taken outside nibble mode");

    // ----------------------------------------
    // checks: serial dma monitor
    // ----------------------------------------
    a_module_code: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
        clk_en |=> dma_module_code == $past(serial_dma_unit_code))
        else $error("module code wrong");
    a_direction_bit: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
        clk_en |=> dma_module_dir == $past(serial_dma_unit_is_rx))
        else $error("direction bit wrong");

    // ----------------------------------------
    // checks: clock enable freeze
    // ----------------------------------------
    // a low enable must hold every flop, pulses included; the checks below cover all of them but rx_nibble
    a_freeze_state: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
        !clk_en |=> ($stable(rx_octet) && $stable(rx_octet_valid) && $stable(rx_cell_start)
        && $stable(rx_cell_end) && $stable(rx_nibble_valid) && $stable(octet_cnt_reg)))
        else $error("state moved while frozen");
    a_monitor_freeze: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
        !clk_en |=> ($stable(dma_module_code) && $stable(dma_module_dir)))
        else $error("monitor moved while frozen");
endmodule : cell_nibble_receive_pins

// file: dv/phy_rx_source.sv
// far-side source model for the receive bus
`timescale 1ns/1ns
module phy_rx_source
    import cell_nibble_rx_pkg::*;
(
    // bus side
    input wire logic clk,
    input wire logic rx_bus_enable_strobe,
    input wire logic have_cell,
    output logic [OCTET_W-1:0] rx_data_pins
);
    localparam logic [OCTET_W-1:0] IDLE_OCTET = 8'h00;
    logic [OCTET_W-1:0] octet_reg = 8'h00;
    logic payload = 1'b0;
    int sent = 0;
    // octets handed over; the model cannot see mode or clock enable, so its borders may drift
    always @(posedge clk)
        if (rx_bus_enable_strobe)
            sent <= (sent == CELL_OCTETS - 1) ? 32'h0 : sent + 32'h1;
    // a whole cell is payload or idle, chosen at each cell border
    always @(negedge clk)
    begin
        if (sent == 32'h0)
            payload <= have_cell;
        octet_reg <= ((sent == 32'h0) ? have_cell : payload) ? OCTET_W'($urandom) : IDLE_OCTET;
    end
    // released bus shows the inverse so a stale sample is caught
    assign rx_data_pins = rx_bus_enable_strobe ? octet_reg : ~octet_reg;
endmodule : phy_rx_source

// file: dv/test_cell_nibble_receive_pins.sv
// self-checking bench for the receive pin block
`timescale 1ns/1ns
module test_cell_nibble_receive_pins;
    import cell_nibble_rx_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b0, rx_bus_enable_strobe = 1'b0, is_rx = 1'b0, have = 1'b0;
    logic [1:0] rx_mode = 2'h0;
    logic [4:0] code = 5'h00, mcode, e_code;
    logic [7:0] pins, oct, e_oct;
    logic [3:0] nib, e_nib;
    logic ov, cs, ce, nv, dir, e_ov, e_cs, e_ce, e_nv, e_dir;
    int cnt, fail_count, cmp_count;
    always #5 clk = ~clk;
    phy_rx_source phy_rx_source_i (.clk(clk), .rx_bus_enable_strobe(rx_bus_enable_strobe), .have_cell(have),
        .rx_data_pins(pins));
    cell_nibble_receive_pins cell_nibble_receive_pins_i (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .rx_mode(rx_mode), .rx_data_pins(pins), .rx_bus_enable_strobe(rx_bus_enable_strobe), .rx_octet(oct),
        .rx_octet_valid(ov), .rx_cell_start(cs), .rx_cell_end(ce), .rx_nibble(nib), .rx_nibble_valid(nv),
        .serial_dma_unit_code(code), .serial_dma_unit_is_rx(is_rx), .dma_module_code(mcode), .dma_module_dir(dir));
    // ----------------------------------------
    // reference model
    // ----------------------------------------
    function automatic int next_count(input int c);
        return (c == CELL_OCTETS - 1) ? 32'h0 : c + 32'h1;
    endfunction : next_count
    // one capture per enabled edge
    always @(posedge clk)
        if (!rst_b)
        begin
            {e_oct, e_nib, e_code, e_ov, e_cs, e_ce, e_nv, e_dir} = '0;
            cnt = 32'h0;
        end
        else if (clk_en)
        begin
            e_code = code;
            e_dir = is_rx;
            {e_ov, e_cs, e_ce} = '0;
            e_nv = (rx_mode == MODE_NIBBLE);
            if (e_nv)
                e_nib = pins[3:0];
            if (rx_mode != MODE_CELL)
                cnt = 32'h0;
            else if (rx_bus_enable_strobe)
            begin
                e_oct = pins;
                e_ov = 1'b1;
                e_cs = (cnt == 32'h0);
                e_ce = (cnt == CELL_OCTETS - 1);
                cnt = next_count(cnt);
            end
        end
    // ----------------------------------------
    // compare tasks
    // ----------------------------------------
    task automatic chk_octet(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_octet
    task automatic chk_nibble(input string n, input logic [3:0] e, input logic [3:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_nibble
    task automatic chk_code(input string n, input logic [4:0] e, input logic [4:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_code
    task automatic chk_flag(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_flag
    task automatic step;
        @(negedge clk);
        chk_octet("octet", e_oct, oct);
        chk_flag("valid", e_ov, ov);
        chk_flag("start", e_cs, cs);
        chk_flag("end", e_ce, ce);
        chk_nibble("nibble", e_nib, nib);
        chk_flag("nvalid", e_nv, nv);
        chk_code("code", e_code, mcode);
        chk_flag("dir", e_dir, dir);
    endtask : step
    task automatic end_of_test;
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        void'($urandom(32'h3F0C));
        repeat (8) @(posedge clk);
        @(negedge clk);
        {rst_b, clk_en, rx_bus_enable_strobe, have} = 4'hF;
        // back-to-back cells, a nibble stretch, then random traffic with mode changes mid-cell
        repeat (120) step;
        rx_mode = MODE_NIBBLE;
        repeat (8) step;
        rx_mode = MODE_CELL;
        for (int i = 0; i < 2000; i++)
        begin
            step;
            // a reset in mid-run must clear every output and the octet count
            rst_b = !(i >= 1000 && i < 1003);
            rx_mode = ($urandom % 32'h8 == 32'h0) ? 2'($urandom) : MODE_CELL;
            clk_en = ($urandom % 32'h8 != 32'h0);
            rx_bus_enable_strobe = ($urandom % 32'h4 != 32'h0);
            have = 1'($urandom);
            code = 5'($urandom);
            is_rx = 1'($urandom);
        end
        end_of_test();
    end
endmodule : test_cell_nibble_receive_pins
